// ### design/dac_control_reg_decode.sv
// serial control-register decode with main and per-channel control registers
//
// What this block does
// - control write only when select field is 111
// - channel field picks A..D for per-channel registers
// - decode control select in D15..D13
// - main control fields at their bit positions
// - idle output follows pin, inverted by polarity
// - watchdog runs when enabled, 5/10/100/200 ms
// - limit select: 16 mA at 0, 8 mA at 1
// - global enable turns on all four outputs
// - global power-up powers all four boosters
// - separate control register for each channel
`timescale 1ns/1ps
`default_nettype none
module dac_control_reg_decode #(
  parameter int CYCLES_PER_MS = dac_ctrl_pkg::CYCLES_PER_MS
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // serial link pins
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  // power-on-condition pin
  input wire logic power_on_pin,
  // register contents
  output var dac_ctrl_pkg::main_ctrl_t main_control,
  output logic [3:0] channel_output_enable,
  output logic [3:0] channel_boost_power,
  output logic idle_level,
  output logic current_limit_8ma,
  output logic readback_active,
  output logic watchdog_timeout,
  // decoded write of the other control registers
  output var dac_ctrl_pkg::ctrl_write_t ctrl_write
);
  logic [2:0] sclk_s;
  logic [2:0] sync_s;
  logic [1:0] sdin_s;
  logic [1:0] pwr_s;
  dac_ctrl_pkg::frame_state_t state, next_state;
  logic [23:0] shreg, next_shreg;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [8:0] dac_ctrl [4];
  logic [8:0] next_dac_ctrl [4];
  dac_ctrl_pkg::main_ctrl_t next_main_control;
  dac_ctrl_pkg::ctrl_write_t next_ctrl_write;
  logic [3:0] next_channel_output_enable, next_channel_boost_power;
  logic next_idle_level, next_current_limit_8ma, next_readback_active;
  logic [31:0] cyc_cnt, next_cyc_cnt;
  logic [7:0] ms_cnt, next_ms_cnt;
  logic next_watchdog_timeout;
  logic sclk_fall, sync_rise, sync_fall, frame_done, frame_full, ctrl_frame;
  logic [2:0] sel;
  logic [1:0] chan;

  function automatic logic [7:0] wd_period(input logic [1:0] code);
    case (code)
      2'b00: wd_period = dac_ctrl_pkg::WD_MS_0;
      2'b01: wd_period = dac_ctrl_pkg::WD_MS_1;
      2'b10: wd_period = dac_ctrl_pkg::WD_MS_2;
      default: wd_period = dac_ctrl_pkg::WD_MS_3;
    endcase
  endfunction : wd_period

  // pin synchronisers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sclk_s <= 3'h0;
      sync_s <= 3'h7;
      sdin_s <= 2'h0;
      pwr_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk};
      sync_s <= {sync_s[1:0], sync_n};
      sdin_s <= {sdin_s[0], sdin};
      pwr_s <= {pwr_s[0], power_on_pin};
    end
  end

  assign sclk_fall = sclk_s[2] & ~sclk_s[1];
  assign sync_rise = ~sync_s[2] & sync_s[1];
  assign sync_fall = sync_s[2] & ~sync_s[1];
  assign frame_done = (state == dac_ctrl_pkg::ST_SHIFT) && sync_rise;
  assign frame_full = frame_done && (bit_cnt == dac_ctrl_pkg::FRAME_LEN);
  assign ctrl_frame = frame_full && !shreg[dac_ctrl_pkg::RW_BIT]
    && (shreg[dac_ctrl_pkg::DATA_SEL_HI:dac_ctrl_pkg::DATA_SEL_LO]
    == dac_ctrl_pkg::DATA_SEL_CONTROL);
  assign sel = shreg[dac_ctrl_pkg::CTRL_SEL_HI:dac_ctrl_pkg::CTRL_SEL_LO];
  assign chan = shreg[dac_ctrl_pkg::CHAN_HI:dac_ctrl_pkg::CHAN_LO];

  // frame shifter
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bit_cnt = bit_cnt;
    case (state)
      dac_ctrl_pkg::ST_IDLE: begin
        if (sync_fall) begin
          next_state = dac_ctrl_pkg::ST_SHIFT;
          next_bit_cnt = 5'h00;
        end
      end
      dac_ctrl_pkg::ST_SHIFT: begin
        if (sync_rise) begin
          next_state = dac_ctrl_pkg::ST_IDLE;
        end else if (sclk_fall) begin
          next_shreg = {shreg[22:0], sdin_s[1]};
          if (bit_cnt != 5'h1F) begin
            next_bit_cnt = bit_cnt + 5'h01;
          end
        end
      end
      default: next_state = dac_ctrl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state <= dac_ctrl_pkg::ST_IDLE;
      shreg <= 24'h000000;
      bit_cnt <= 5'h00;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      bit_cnt <= next_bit_cnt;
    end
  end

  // register file and derived outputs
  always_comb begin
    logic [3:0] enable_vec;
    logic [3:0] boost_vec;
    enable_vec = 4'h0;
    boost_vec = 4'h0;
    next_main_control = main_control;
    for (int i = 0; i < 4; i++) begin
      next_dac_ctrl[i] = dac_ctrl[i];
    end
    next_ctrl_write = '0;
    if (ctrl_frame) begin
      case (sel)
        dac_ctrl_pkg::SEL_MAIN: begin
          next_main_control.idle_output_polarity = shreg[dac_ctrl_pkg::POS_POLARITY];
          next_main_control.status_readback_enable = shreg[dac_ctrl_pkg::POS_READBACK];
          next_main_control.watchdog_enable = shreg[dac_ctrl_pkg::POS_WD_ENABLE];
          next_main_control.timeout_select_hi = shreg[dac_ctrl_pkg::POS_WD_HI];
          next_main_control.timeout_select_lo = shreg[dac_ctrl_pkg::POS_WD_LO];
          next_main_control.short_limit_select = shreg[dac_ctrl_pkg::POS_SHORT_LIMIT];
          next_main_control.global_output_enable = shreg[dac_ctrl_pkg::POS_OUT_ALL];
          next_main_control.global_boost_powerup = shreg[dac_ctrl_pkg::POS_BOOST_ALL];
        end
        dac_ctrl_pkg::SEL_DAC_CTRL: begin
          next_dac_ctrl[chan] = shreg[dac_ctrl_pkg::DAC_CTRL_W-1:0];
        end
        dac_ctrl_pkg::SEL_SLEW, dac_ctrl_pkg::SEL_BOOST_CTRL, dac_ctrl_pkg::SEL_SOFTWARE: begin
          next_ctrl_write.strobe = 1'b1;
          next_ctrl_write.select = sel;
          next_ctrl_write.channel = chan;
          next_ctrl_write.payload = shreg[12:0];
        end
        default: next_ctrl_write.strobe = 1'b0;
      endcase
    end
    for (int i = 0; i < 4; i++) begin
      enable_vec[i] = next_dac_ctrl[i][dac_ctrl_pkg::POS_CH_ENABLE];
      boost_vec[i] = next_dac_ctrl[i][dac_ctrl_pkg::POS_CH_BOOST];
    end
    next_channel_output_enable = enable_vec | {4{next_main_control.global_output_enable}};
    next_channel_boost_power = boost_vec | {4{next_main_control.global_boost_powerup}};
    next_idle_level = pwr_s[1] ^ next_main_control.idle_output_polarity;
    next_current_limit_8ma = next_main_control.short_limit_select;
    next_readback_active = main_control.status_readback_enable
      && (next_state == dac_ctrl_pkg::ST_SHIFT);
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      main_control <= dac_ctrl_pkg::MAIN_RESET;
      for (int i = 0; i < 4; i++) begin
        dac_ctrl[i] <= dac_ctrl_pkg::DAC_CTRL_RESET;
      end
      ctrl_write <= '0;
      channel_output_enable <= 4'h0;
      channel_boost_power <= 4'h0;
      idle_level <= 1'b0;
      current_limit_8ma <= 1'b0;
      readback_active <= 1'b0;
    end else begin
      main_control <= next_main_control;
      for (int i = 0; i < 4; i++) begin
        dac_ctrl[i] <= next_dac_ctrl[i];
      end
      ctrl_write <= next_ctrl_write;
      channel_output_enable <= next_channel_output_enable;
      channel_boost_power <= next_channel_boost_power;
      idle_level <= next_idle_level;
      current_limit_8ma <= next_current_limit_8ma;
      readback_active <= next_readback_active;
    end
  end

  // watchdog: restarted by every full frame
  always_comb begin
    next_cyc_cnt = cyc_cnt;
    next_ms_cnt = ms_cnt;
    next_watchdog_timeout = 1'b0;
    if (!main_control.watchdog_enable || frame_full) begin
      next_cyc_cnt = 32'h00000000;
      next_ms_cnt = 8'h00;
    end else if (cyc_cnt == 32'(CYCLES_PER_MS - 1)) begin
      next_cyc_cnt = 32'h00000000;
      if (ms_cnt == wd_period({main_control.timeout_select_hi,
                               main_control.timeout_select_lo}) - 8'h01) begin
        next_ms_cnt = 8'h00;
        next_watchdog_timeout = 1'b1;
      end else begin
        next_ms_cnt = ms_cnt + 8'h01;
      end
    end else begin
      next_cyc_cnt = cyc_cnt + 32'h00000001;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cyc_cnt <= 32'h00000000;
      ms_cnt <= 8'h00;
      watchdog_timeout <= 1'b0;
    end else begin
      cyc_cnt <= next_cyc_cnt;
      ms_cnt <= next_ms_cnt;
      watchdog_timeout <= next_watchdog_timeout;
    end
  end

  // checks
  short_frame_a: assert property (@(posedge clock) disable iff (!rstn)
    (frame_done && bit_cnt != dac_ctrl_pkg::FRAME_LEN) |=> $stable(main_control))
    else $error("short frame changed main control");
  main_update_a: assert property (@(posedge clock) disable iff (!rstn)
    (ctrl_frame && sel == dac_ctrl_pkg::SEL_MAIN) |=>
    main_control.short_limit_select == $past(shreg[dac_ctrl_pkg::POS_SHORT_LIMIT]))
    else $error("main control field not loaded");
  non_control_a: assert property (@(posedge clock) disable iff (!rstn)
    (frame_full && shreg[20:18] != 3'h7) |=> $stable(main_control) && !ctrl_write.strobe)
    else $error("data frame decoded as control");
  channel_reg_a: assert property (@(posedge clock) disable iff (!rstn)
    (ctrl_frame && sel == dac_ctrl_pkg::SEL_DAC_CTRL) |=> dac_ctrl[$past(chan)] == $past(shreg[8:0]))
    else $error("channel control not loaded");
  global_channel_output_enable_a: assert property (@(posedge clock) disable iff (!rstn)
    main_control.global_output_enable |-> channel_output_enable == 4'hF)
    else $error("global enable missed a channel");
  global_boost_a: assert property (@(posedge clock) disable iff (!rstn)
    main_control.global_boost_powerup |-> channel_boost_power == 4'hF)
    else $error("global power-up missed a channel");
  idle_level_a: assert property (@(posedge clock) disable iff (!rstn)
    1'b1 |=> idle_level == ($past(pwr_s[1]) ^ main_control.idle_output_polarity))
    else $error("idle level wrong");
  limit_sel_a: assert property (@(posedge clock) disable iff (!rstn)
    (ctrl_frame && sel == dac_ctrl_pkg::SEL_MAIN) |=>
    current_limit_8ma == $past(shreg[dac_ctrl_pkg::POS_SHORT_LIMIT]))
    else $error("current limit select wrong");
  readback_gate_a: assert property (@(posedge clock) disable iff (!rstn)
    !$past(main_control.status_readback_enable) |-> !readback_active)
    else $error("readback while disabled");
  wd_off_a: assert property (@(posedge clock) disable iff (!rstn)
    !main_control.watchdog_enable |=> !watchdog_timeout && ms_cnt == 8'h00)
    else $error("watchdog ran while disabled");
endmodule : dac_control_reg_decode
`default_nettype wire

// ### design/dac_ctrl_pkg.sv
// constants and types for the control-register decode block
package dac_ctrl_pkg;
  // serial frame layout
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] FRAME_LEN = 5'h18;
  localparam int RW_BIT = 23;
  localparam int DATA_SEL_HI = 20;
  localparam int DATA_SEL_LO = 18;
  localparam int CHAN_HI = 17;
  localparam int CHAN_LO = 16;
  localparam int CTRL_SEL_HI = 15;
  localparam int CTRL_SEL_LO = 13;
  localparam logic [2:0] DATA_SEL_CONTROL = 3'h7;
  // control select codes
  localparam logic [2:0] SEL_SLEW = 3'h0;
  localparam logic [2:0] SEL_MAIN = 3'h1;
  localparam logic [2:0] SEL_DAC_CTRL = 3'h2;
  localparam logic [2:0] SEL_BOOST_CTRL = 3'h3;
  localparam logic [2:0] SEL_SOFTWARE = 3'h4;
  // main control field positions
  localparam int POS_POLARITY = 12;
  localparam int POS_READBACK = 11;
  localparam int POS_WD_ENABLE = 10;
  localparam int POS_WD_HI = 9;
  localparam int POS_WD_LO = 8;
  localparam int POS_SHORT_LIMIT = 6;
  localparam int POS_OUT_ALL = 5;
  localparam int POS_BOOST_ALL = 4;
  // per-channel control field positions and width
  localparam int DAC_CTRL_W = 9;
  localparam int POS_CH_ENABLE = 6;
  localparam int POS_CH_BOOST = 4;
  localparam logic [8:0] DAC_CTRL_RESET = 9'h000;
  localparam logic [12:0] PAYLOAD_RESET = 13'h0000;
  // watchdog timing
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int NS_PER_MS = 1000000;
  localparam int CYCLES_PER_MS = NS_PER_MS / CLOCK_PERIOD_NS;
  localparam logic [7:0] WD_MS_0 = 8'h05;
  localparam logic [7:0] WD_MS_1 = 8'h0A;
  localparam logic [7:0] WD_MS_2 = 8'h64;
  localparam logic [7:0] WD_MS_3 = 8'hC8;

  typedef struct packed {
    logic idle_output_polarity;
    logic status_readback_enable;
    logic watchdog_enable;
    logic timeout_select_hi;
    logic timeout_select_lo;
    logic short_limit_select;
    logic global_output_enable;
    logic global_boost_powerup;
  } main_ctrl_t;

  localparam main_ctrl_t MAIN_RESET = '0;

  typedef struct packed {
    logic strobe;
    logic [2:0] select;
    logic [1:0] channel;
    logic [12:0] payload;
  } ctrl_write_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } frame_state_t;
endpackage : dac_ctrl_pkg

// ### testbench/host_link_model.sv
// host side model that drives control frames onto the serial link
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  // serial link pins
  output var logic sclk,
  output var logic sync_n,
  output var logic sdin
);
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdin = 1'b0;
  end
  // msb first, data set while sclk high, bits past 24 are zeros
  task automatic send(input logic [23:0] word, input int nbits);
    // step off the sampling edge so no pin moves on a rising clock
    #1;
    sync_n = 1'b0;
    #62.5;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b1;
      sdin = (i < 24) ? word[23 - i] : 1'b0;
      #62.5;
      sclk = 1'b0;
      #62.5;
    end
    sclk = 1'b1;
    #62.5;
    sync_n = 1'b1;
    sdin = ~sdin;
    #100;
  endtask : send
endmodule : host_link_model
`default_nettype wire

// ### testbench/tb_dac_control_reg_decode.sv
// self-checking bench for the control-register decode block
`timescale 1ns/1ps
`default_nettype none
module tb_dac_control_reg_decode;
  typedef struct packed {
    logic [2:0] sel;
    logic [1:0] ch;
    logic [12:0] pay;
    logic [7:0] main;
    logic [3:0] oe;
    logic [3:0] bp;
  } row_t;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic power_on_pin = 1'b0;
  wire logic sclk, sync_n, sdin;
  dac_ctrl_pkg::main_ctrl_t main_control;
  logic [3:0] channel_output_enable, channel_boost_power;
  logic idle_level, current_limit_8ma, readback_active, watchdog_timeout;
  dac_ctrl_pkg::ctrl_write_t ctrl_write, cw_last;
  int mismatches = 0, comparisons = 0, cyc = 0, strobes = 0, wd_count = 0;
  int last_cyc = 0, gap = 0, rb_cnt = 0;
  row_t rows[8] = '{{3'h1, 2'h0, 13'h18AF, 8'hC2, 4'hF, 4'h0},
    {3'h1, 2'h3, 13'h0350, 8'h1D, 4'h0, 4'hF}, {3'h1, 2'h0, 13'h0000, 8'h00, 4'h0, 4'h0},
    {3'h2, 2'h2, 13'h1E50, 8'h00, 4'h4, 4'h4}, {3'h2, 2'h0, 13'h0040, 8'h00, 4'h5, 4'h4},
    {3'h2, 2'h1, 13'h0050, 8'h00, 4'h7, 4'h6}, {3'h2, 2'h3, 13'h0010, 8'h00, 4'h7, 4'hE},
    {3'h2, 2'h3, 13'h0000, 8'h00, 4'h7, 4'h6}};

  always #2.5 clock = ~clock;

  host_link_model u_host_link_model (.sclk(sclk), .sync_n(sync_n), .sdin(sdin));
  dac_control_reg_decode #(.CYCLES_PER_MS(10)) u_dac_control_reg_decode (
    .clock(clock), .rstn(rstn), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
    .power_on_pin(power_on_pin), .main_control(main_control),
    .channel_output_enable(channel_output_enable), .channel_boost_power(channel_boost_power),
    .idle_level(idle_level), .current_limit_8ma(current_limit_8ma),
    .readback_active(readback_active), .watchdog_timeout(watchdog_timeout),
    .ctrl_write(ctrl_write));

  task automatic complete_run();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [23:0] mk(input logic [2:0] sel, input logic [1:0] ch,
                                     input logic [12:0] pay);
    return {3'h0, dac_ctrl_pkg::DATA_SEL_CONTROL, ch, sel, pay};
  endfunction : mk

  task automatic frame(input logic [23:0] w, input int n);
    u_host_link_model.send(w, n);
    @(posedge clock);
  endtask : frame

  // event monitors and hang limit
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (readback_active === 1'b1) rb_cnt <= rb_cnt + 1;
    if (ctrl_write.strobe === 1'b1) begin
      strobes <= strobes + 1;
      cw_last <= ctrl_write;
    end
    if (watchdog_timeout === 1'b1) begin
      wd_count <= wd_count + 1;
      gap <= cyc - last_cyc;
      last_cyc <= cyc;
    end
    if (cyc == 60000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    int base;
    logic prev_rb;
    logic [23:0] bw[5];
    int bn[5];
    logic [2:0] sl[3];
    logic [7:0] ms[4];
    prev_rb = 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (5) @(posedge clock);
    check({main_control, channel_output_enable, channel_boost_power}, 0);
    for (int i = 0; i < 8; i++) begin
      power_on_pin <= i[0];
      base = rb_cnt;
      frame(mk(rows[i].sel, rows[i].ch, rows[i].pay), 24);
      check(main_control, rows[i].main);
      check(channel_output_enable, rows[i].oe);
      check(channel_boost_power, rows[i].bp);
      check(current_limit_8ma, rows[i].main[2]);
      check(idle_level, i[0] ^ rows[i].main[7]);
      check(rb_cnt != base, prev_rb);
      prev_rb = rows[i].main[6];
    end
    // read frame, wrong data select, unused select, short and long frames
    bw = '{mk(3'h1, 2'h0, 13'h1FFF) | 24'h800000, mk(3'h1, 2'h0, 13'h1FFF) ^ 24'h040000,
      mk(3'h5, 2'h0, 13'h1FFF), mk(3'h1, 2'h0, 13'h1FFF), mk(3'h1, 2'h0, 13'h1FFF)};
    bn = '{24, 24, 24, 23, 25};
    base = strobes;
    for (int i = 0; i < 5; i++) frame(bw[i], bn[i]);
    check(main_control, 8'h00);
    check(channel_output_enable, 4'h7);
    check(strobes - base, 0);
    sl = '{dac_ctrl_pkg::SEL_SLEW, dac_ctrl_pkg::SEL_BOOST_CTRL, dac_ctrl_pkg::SEL_SOFTWARE};
    for (int i = 0; i < 3; i++) begin
      base = strobes;
      frame(mk(sl[i], 2'h3, 13'h1ABC), 24);
      check(strobes - base, 1);
      check(cw_last, {1'b1, sl[i], 2'h3, 13'h1ABC});
    end
    ms = '{dac_ctrl_pkg::WD_MS_0, dac_ctrl_pkg::WD_MS_1, dac_ctrl_pkg::WD_MS_2,
      dac_ctrl_pkg::WD_MS_3};
    for (int i = 0; i < 4; i++) begin
      frame(mk(3'h1, 2'h0, 13'(32'h400 + i * 256)), 24);
      base = wd_count;
      repeat (ms[i] * 20 + 20) @(posedge clock);
      check(wd_count - base >= 2, 1);
      check(gap, ms[i] * 10);
    end
    frame(mk(3'h1, 2'h0, 13'h1040), 24);
    base = wd_count;
    repeat (300) @(posedge clock);
    check(wd_count - base, 0);
    check({main_control, current_limit_8ma}, {8'h84, 1'b1});
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    check({main_control, channel_output_enable, channel_boost_power, current_limit_8ma}, 0);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    check({channel_output_enable, channel_boost_power}, 0);
    frame(mk(3'h2, 2'h1, 13'h0040), 24);
    check(channel_output_enable, 4'h2);
    complete_run();
  end
endmodule : tb_dac_control_reg_decode
`default_nettype wire
